//--- hdl/rx_err_pkg.sv
// constants shared by the receive-side error and configuration registers
`default_nettype none
package rx_err_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int DLANES = 3;
   localparam int LANES  = 4;
   localparam int LANE_FAULT_W = 5;
   localparam int CLK_FAULT_W  = 4;

   localparam logic [7:0] OFF_LANE1_ERR = 8'h11;
   localparam logic [7:0] OFF_LANE2_ERR = 8'h12;
   localparam logic [7:0] OFF_LANE3_ERR = 8'h13;
   localparam logic [7:0] OFF_CLK_ERR   = 8'h14;
   localparam logic [7:0] OFF_SYNC_SNAP = 8'h15;
   localparam logic [7:0] OFF_CFG_PRI   = 8'h20;
   localparam logic [7:0] OFF_CFG_SEC   = 8'h21;
   localparam logic [7:0] OFF_ERR_CFG   = 8'h23;
   localparam logic [7:0] OFF_PROT_STS  = 8'h28;

   localparam logic [7:0] RST_CFG_PRI = 8'h7F;
   localparam logic [7:0] RST_CFG_SEC = 8'h00;
   localparam logic [7:0] RST_ERR_CFG = 8'h7F;
   localparam logic [7:0] RST_FLAGS   = 8'h00;

   // data lane error fields
   localparam int LE_END_SYNC   = 4;
   localparam int LE_START_BIT  = 3;
   localparam int LE_START_SYNC = 2;
   localparam int LE_FAST_CTRL  = 1;
   localparam int LE_FAST_TO    = 0;
   // clock lane error fields
   localparam int CE_SLEEP_REQ  = 3;
   localparam int CE_FAST_REQ   = 2;
   localparam int CE_BAD_SLEEP  = 1;
   localparam int CE_FAST_TO    = 0;
   // primary configuration fields
   localparam int CP_RECOVER    = 6;
   localparam int CP_DROP_CMD   = 5;
   localparam int CP_SYNC_REGEN = 4;
   localparam int CP_VC_LSB     = 0;
   localparam logic [7:0] CP_WR_MASK = 8'h7F;
   // secondary configuration fields
   localparam int CS_NO_GRAY    = 7;
   localparam int CS_VS_INV     = 6;
   localparam int CS_HS_INV     = 5;
   localparam int CS_HOLD_ERR   = 4;
   localparam int CS_BLANK_CHK  = 3;
   localparam int CS_NO_FILTER  = 1;
   localparam int CS_NO_ENDPKT  = 0;
   // error configuration and protocol status fields
   localparam int EC_BAD_VC_EN  = 3;
   localparam logic [7:0] EC_WR_MASK = 8'h7F;
   localparam int PS_END_ERR    = 2;
   localparam int PS_ERR_DET    = 0;
   // narrow colour widths
   localparam logic [3:0] W_RB = 4'd5;
   localparam logic [3:0] W_G  = 4'd6;
endpackage
`default_nettype wire

//--- hdl/sync3.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`default_nettype none
module sync3 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] q_ff;
   wire  [W-1:0] agree = ~(s2_ff ^ s3_ff);
   wire  [W-1:0] nxt_q = (agree & s3_ff) | (~agree & q_ff);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         q_ff  <= '0;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff  <= nxt_q;
      end
   end

   assign q = q_ff;
endmodule // sync3
`default_nettype wire

//--- hdl/video_rx_error_config_regs.sv
// lane error flags, sync snapshot and protocol configuration registers
//
// Implementation choice: the strobed register port.
`default_nettype none
module video_rx_error_config_regs (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic [rx_err_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [rx_err_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [rx_err_pkg::DATA_W-1:0] reg_rdata,
   input  wire logic                       link_clk,
   input  wire logic [14:0]                lane_fault_in,
   input  wire logic [3:0]                 clock_lane_fault_in,
   input  wire logic [3:0]                 lane_sync_seen,
   input  wire logic [3:0]                 lane_enabled,
   input  wire logic                       pkt_valid,
   input  wire logic [1:0]                 pkt_vc,
   input  wire logic                       pkt_is_fast_cmd,
   input  wire logic                       pkt_wc_bad,
   input  wire logic                       pkt_is_blank,
   input  wire logic                       pkt_crc_bad,
   input  wire logic                       tx_end,
   input  wire logic                       tx_end_pkt_seen,
   input  wire logic                       vs_in,
   input  wire logic                       hs_in,
   input  wire logic                       pixel_valid,
   input  wire logic                       pixel_narrow,
   input  wire logic [23:0]                pixel_in,
   output logic                            pkt_accept,
   output logic                            pkt_vc_error,
   output logic                            auto_recover_enable,
   output logic                            vsync_out,
   output logic                            hsync_out,
   output logic      [23:0]                pixel_out,
   output logic                            error_indication,
   output logic                            lane_sync_error
);
   import rx_err_pkg::*;

   logic [7:0]  lane_err_ff [DLANES];
   logic [7:0]  clk_err_ff;
   logic [7:0]  sync_snap_ff;
   logic [7:0]  cfg_pri_ff;
   logic [7:0]  cfg_sec_ff;
   logic [7:0]  err_cfg_ff;
   logic [7:0]  prot_sts_ff;
   logic        lane_sync_err_ff;
   logic [7:0]  rdata_ff;
   logic        link_q_ff;
   logic        accept_ff;
   logic        vc_err_ff;
   logic        vs_ff;
   logic        hs_ff;
   logic [23:0] pix_ff;
   logic        err_out_ff;

   // link-side levels cross with the three-stage filter
   logic [27:0] link_sync;
   sync3 #(.W(28)) u_link_sync (
      .clk (clk),
      .rst (rst),
      .d   ({link_clk, lane_enabled, lane_sync_seen,
             clock_lane_fault_in, lane_fault_in}),
      .q   (link_sync)
   );

   wire        link_lvl   = link_sync[27];
   wire [3:0]  en_lanes   = link_sync[26:23];
   wire [3:0]  seen_lanes = link_sync[22:19];
   wire [3:0]  clk_fault  = link_sync[18:15];
   wire [14:0] lane_fault = link_sync[14:0];
   // lane faults are sampled once per rising link edge
   wire        link_rise  = link_lvl & ~link_q_ff;
   wire [14:0] lane_evt   = link_rise ? lane_fault : 15'h0000;
   wire [3:0]  clk_evt    = link_rise ? clk_fault : 4'h0;

   // sync mismatch: some enabled lane saw sync, not all of them
   wire [3:0]  seen_en    = seen_lanes & en_lanes;
   wire        sync_mis   = link_rise && (seen_en != 4'h0)
                            && (seen_en != en_lanes);

   wire        wr_pri   = reg_wr && (reg_addr == OFF_CFG_PRI);
   wire        wr_sec   = reg_wr && (reg_addr == OFF_CFG_SEC);
   wire        wr_ecfg  = reg_wr && (reg_addr == OFF_ERR_CFG);
   wire        rd_clk   = reg_rd && (reg_addr == OFF_CLK_ERR);
   wire        rd_snap  = reg_rd && (reg_addr == OFF_SYNC_SNAP);
   wire        rd_sts   = reg_rd && (reg_addr == OFF_PROT_STS);
   wire [2:0]  rd_lane;
   assign rd_lane[0] = reg_rd && (reg_addr == OFF_LANE1_ERR);
   assign rd_lane[1] = reg_rd && (reg_addr == OFF_LANE2_ERR);
   assign rd_lane[2] = reg_rd && (reg_addr == OFF_LANE3_ERR);

   // protocol events on the core clock
   wire        vc_ok    = cfg_pri_ff[CP_VC_LSB + pkt_vc];
   wire        bad_vc   = pkt_valid && !vc_ok;
   wire        crc_evt  = pkt_valid && pkt_crc_bad
                          && !(pkt_is_blank && cfg_sec_ff[CS_BLANK_CHK]);
   wire        end_evt  = tx_end && !tx_end_pkt_seen
                          && !cfg_sec_ff[CS_NO_ENDPKT];
   wire        sum_evt  = (bad_vc && err_cfg_ff[EC_BAD_VC_EN])
                          || crc_evt || end_evt;
   wire        drop_cmd = pkt_is_fast_cmd && cfg_pri_ff[CP_DROP_CMD];
   wire        drop_wc  = pkt_wc_bad && !cfg_sec_ff[CS_NO_FILTER];
   // channel enables never filter; only command and length checks drop
   wire        nxt_accept = pkt_valid && !drop_cmd && !drop_wc;

   // sticky flags: a set in the clearing cycle wins
   wire [7:0]  nxt_clk_err = (clk_err_ff & ~{8{rd_clk}})
                             | {4'h0, clk_evt};
   wire [7:0]  sts_set     = {5'h00, end_evt, 1'b0, sum_evt};
   wire [7:0]  nxt_sts     = (prot_sts_ff & ~{8{rd_sts}}) | sts_set;
   wire        nxt_ls_err  = (lane_sync_err_ff & ~rd_snap) | sync_mis;

   // read-back mux, reserved bits read zero
   wire [7:0]  rd_mux =
      (reg_addr == OFF_LANE1_ERR) ? lane_err_ff[0] :
      (reg_addr == OFF_LANE2_ERR) ? lane_err_ff[1] :
      (reg_addr == OFF_LANE3_ERR) ? lane_err_ff[2] :
      (reg_addr == OFF_CLK_ERR)   ? clk_err_ff :
      (reg_addr == OFF_SYNC_SNAP) ? sync_snap_ff :
      (reg_addr == OFF_CFG_PRI)   ? cfg_pri_ff :
      (reg_addr == OFF_CFG_SEC)   ? cfg_sec_ff :
      (reg_addr == OFF_ERR_CFG)   ? err_cfg_ff :
      (reg_addr == OFF_PROT_STS)  ? prot_sts_ff : 8'h00;

   // widen a narrow colour to 8 bits, optionally copying its top bits down
   function automatic logic [7:0] widen(input logic [7:0] v,
                                        input logic [3:0] w,
                                        input logic       fill);
      logic [7:0] s;
      s = v << (4'd8 - w);
      widen = s | (fill ? (s >> w) : 8'h00);
   endfunction

   wire        gray_fill = !cfg_sec_ff[CS_NO_GRAY];
   wire [23:0] pix_wide  = {widen({3'b000, pixel_in[15:11]}, W_RB, gray_fill),
                            widen({2'b00, pixel_in[10:5]}, W_G, gray_fill),
                            widen({3'b000, pixel_in[4:0]}, W_RB, gray_fill)};
   wire [23:0] nxt_pix   = pixel_narrow ? pix_wide : pixel_in;

   // with regeneration off the syncs rest at their inactive level
   wire        regen     = cfg_pri_ff[CP_SYNC_REGEN];
   wire        nxt_vs    = (regen & vs_in) ^ cfg_sec_ff[CS_VS_INV];
   wire        nxt_hs    = (regen & hs_in) ^ cfg_sec_ff[CS_HS_INV];
   wire        nxt_err_o = cfg_sec_ff[CS_HOLD_ERR] ? nxt_sts[PS_ERR_DET]
                                                   : sum_evt;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < DLANES; i++) begin
            lane_err_ff[i] <= RST_FLAGS;
         end
      end else begin
         for (int i = 0; i < DLANES; i++) begin
            lane_err_ff[i] <= (lane_err_ff[i] & ~{8{rd_lane[i]}})
               | {3'b000, lane_evt[i*LANE_FAULT_W +: LANE_FAULT_W]};
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clk_err_ff       <= RST_FLAGS;
         prot_sts_ff      <= RST_FLAGS;
         sync_snap_ff     <= RST_FLAGS;
         lane_sync_err_ff <= 1'b0;
         link_q_ff        <= 1'b0;
      end else begin
         clk_err_ff       <= nxt_clk_err;
         prot_sts_ff      <= nxt_sts;
         lane_sync_err_ff <= nxt_ls_err;
         link_q_ff        <= link_lvl;
         if (sync_mis) begin
            sync_snap_ff <= {4'h0, seen_lanes};
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_pri_ff <= RST_CFG_PRI;
         cfg_sec_ff <= RST_CFG_SEC;
         err_cfg_ff <= RST_ERR_CFG;
      end else begin
         if (wr_pri) begin
            cfg_pri_ff <= reg_wdata & CP_WR_MASK;
         end
         if (wr_sec) begin
            cfg_sec_ff <= reg_wdata;
         end
         if (wr_ecfg) begin
            err_cfg_ff <= reg_wdata & EC_WR_MASK;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_ff   <= 8'h00;
         accept_ff  <= 1'b0;
         vc_err_ff  <= 1'b0;
         vs_ff      <= 1'b0;
         hs_ff      <= 1'b0;
         pix_ff     <= 24'h000000;
         err_out_ff <= 1'b0;
      end else begin
         rdata_ff   <= reg_rd ? rd_mux : 8'h00;
         accept_ff  <= nxt_accept;
         vc_err_ff  <= bad_vc;
         vs_ff      <= nxt_vs;
         hs_ff      <= nxt_hs;
         err_out_ff <= nxt_err_o;
         if (pixel_valid) begin
            pix_ff <= nxt_pix;
         end
      end
   end

   assign reg_rdata           = rdata_ff;
   assign pkt_accept          = accept_ff;
   assign pkt_vc_error        = vc_err_ff;
   assign auto_recover_enable = cfg_pri_ff[CP_RECOVER];
   assign vsync_out           = vs_ff;
   assign hsync_out           = hs_ff;
   assign pixel_out           = pix_ff;
   assign error_indication    = err_out_ff;
   assign lane_sync_error     = lane_sync_err_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_mismatch;
      sync_mis && !rd_snap;
   endsequence
   sequence s_snap_taken;
      lane_sync_error && (sync_snap_ff[3:0] == $past(seen_lanes));
   endsequence
   sequence s_narrow_fill;
      pixel_valid && pixel_narrow && !cfg_sec_ff[CS_NO_GRAY];
   endsequence
   sequence s_narrow_plain;
      pixel_valid && pixel_narrow && cfg_sec_ff[CS_NO_GRAY];
   endsequence

   chk_lane_end_sync: assert property (
      lane_evt[LE_END_SYNC] |=> lane_err_ff[0][LE_END_SYNC])
      else $error("lane 1 end sync fault not latched");
   chk_lane_read_clear: assert property (
      (rd_lane[1] && lane_evt[9:5] == 5'h00)
      |=> (lane_err_ff[1] == 8'h00) && (reg_rdata == $past(lane_err_ff[1])))
      else $error("lane 2 read did not return then clear");
   chk_lane_fast_ctrl: assert property (
      lane_evt[2*LANE_FAULT_W + LE_FAST_CTRL] |=> lane_err_ff[2][LE_FAST_CTRL]
      ##1 (lane_err_ff[2][LE_FAST_CTRL] || $past(rd_lane[2])))
      else $error("lane 3 fast request fault lost");
   chk_clk_lane_flag: assert property (
      clk_evt[CE_SLEEP_REQ] |=> clk_err_ff[CE_SLEEP_REQ]
      && clk_err_ff[7:4] == 4'h0)
      else $error("clock lane sleep fault not latched");
   chk_sync_snapshot: assert property (
      s_mismatch |=> s_snap_taken)
      else $error("sync mismatch not captured");
   chk_recover_write: assert property (
      wr_pri |=> auto_recover_enable == $past(reg_wdata[CP_RECOVER]))
      else $error("recovery enable did not follow write");
   chk_cmd_dropped: assert property (
      (pkt_valid && pkt_is_fast_cmd && cfg_pri_ff[CP_DROP_CMD])
      |=> !pkt_accept)
      else $error("fast command accepted while dropping");
   chk_vc_not_filtered: assert property (
      (bad_vc && !pkt_is_fast_cmd && !pkt_wc_bad)
      |=> pkt_accept && pkt_vc_error)
      else $error("disabled channel packet mishandled");
   chk_vsync_polarity: assert property (
      regen |=> vsync_out == ($past(vs_in) ^ $past(cfg_sec_ff[CS_VS_INV])))
      else $error("vertical sync polarity wrong");
   chk_error_pulse: assert property (
      (sum_evt && !cfg_sec_ff[CS_HOLD_ERR]) ##1 !sum_evt
      |=> !error_indication)
      else $error("pulse mode error indication did not end");
   chk_end_pkt_flag: assert property (
      end_evt |=> prot_sts_ff[PS_END_ERR] && prot_sts_ff[PS_ERR_DET])
      else $error("missing end packet not flagged");
   chk_hsync_polarity: assert property (
      regen |=> hsync_out == ($past(hs_in) ^ $past(cfg_sec_ff[CS_HS_INV])))
      else $error("horizontal sync polarity wrong");
   chk_sync_idle: assert property (
      !regen |=> vsync_out == $past(cfg_sec_ff[CS_VS_INV])
      && hsync_out == $past(cfg_sec_ff[CS_HS_INV]))
      else $error("syncs not idle with regeneration off");
   chk_pixel_fill: assert property (
      s_narrow_fill |=> pixel_out[18:16] == pixel_out[23:21]
      && pixel_out[9:8] == pixel_out[15:14]
      && pixel_out[2:0] == pixel_out[7:5])
      else $error("narrow pixel low bits not filled");
   chk_pixel_plain: assert property (
      s_narrow_plain |=> pixel_out[18:16] == 3'h0
      && pixel_out[9:8] == 2'h0 && pixel_out[2:0] == 3'h0)
      else $error("narrow pixel low bits not zero");
   chk_wc_filter: assert property (
      (pkt_valid && pkt_wc_bad && !cfg_sec_ff[CS_NO_FILTER])
      |=> !pkt_accept)
      else $error("bad word count packet accepted");
   chk_packet_kept: assert property (
      (pkt_valid && !pkt_is_fast_cmd && !pkt_wc_bad) |=> pkt_accept)
      else $error("plain packet dropped");
   chk_crc_summary: assert property (
      (pkt_valid && pkt_crc_bad
       && !(pkt_is_blank && cfg_sec_ff[CS_BLANK_CHK]))
      |=> prot_sts_ff[PS_ERR_DET])
      else $error("checksum error not summarised");
   chk_bad_vc_summary: assert property (
      (bad_vc && err_cfg_ff[EC_BAD_VC_EN]) |=> prot_sts_ff[PS_ERR_DET])
      else $error("enabled channel error not summarised");
   chk_clk_read_clear: assert property (
      (rd_clk && clk_evt == 4'h0)
      |=> (clk_err_ff == 8'h00) && (reg_rdata == $past(clk_err_ff)))
      else $error("clock lane read did not return then clear");
   chk_error_level: assert property (
      (sum_evt && cfg_sec_ff[CS_HOLD_ERR]) |=> error_indication)
      else $error("held error indication not raised");
   chk_end_pkt_off: assert property (
      (cfg_sec_ff[CS_NO_ENDPKT] && !prot_sts_ff[PS_END_ERR])
      |=> !prot_sts_ff[PS_END_ERR])
      else $error("end packet error raised while disabled");
   chk_snapshot_hold: assert property (
      !sync_mis |=> $stable(sync_snap_ff))
      else $error("sync snapshot changed without a mismatch");
endmodule // video_rx_error_config_regs
`default_nettype wire

//--- verif/host_lane_model.sv
// host-side lane model: link clock bursts carrying lane fault and sync levels
`default_nettype none
module host_lane_model (
   input  wire logic        go,
   input  wire logic [14:0] f_lane,
   input  wire logic [3:0]  f_clk,
   input  wire logic [3:0]  f_seen,
   output logic             link_clk,
   output logic      [14:0] lane_fault_in,
   output logic      [3:0]  clock_lane_fault_in,
   output logic      [3:0]  lane_sync_seen
);
   timeunit 1ns;
   timeprecision 1ns;
   // one link period per request; the clock stands still between bursts,
   // and every change sits 5 ns off the core clock edge so none races it
   initial begin
      {link_clk, lane_fault_in, clock_lane_fault_in, lane_sync_seen} =
         24'h0;
      forever begin
         @(posedge go);
         #5 {lane_fault_in, clock_lane_fault_in, lane_sync_seen} =
            {f_lane, f_clk, f_seen};
         #80 link_clk = 1'b1;
         #80 link_clk = 1'b0;
         // levels invert after the falling edge so stale values never match
         {lane_fault_in, clock_lane_fault_in, lane_sync_seen} =
            ~{f_lane, f_clk, f_seen};
      end
   end
endmodule // host_lane_model
`default_nettype wire

//--- verif/video_rx_error_config_regs_test.sv
// self-checking bench for the lane error and configuration registers
`default_nettype none
module video_rx_error_config_regs_test;
   timeunit 1ns;
   timeprecision 1ns;
   import rx_err_pkg::*;
   localparam logic [7:0] OFFS [10] = '{OFF_LANE1_ERR, OFF_LANE2_ERR,
      OFF_LANE3_ERR, OFF_CLK_ERR, OFF_SYNC_SNAP, OFF_CFG_PRI, OFF_CFG_SEC,
      OFF_ERR_CFG, OFF_PROT_STS, 8'h30};
   localparam logic [7:0] RSTV [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h7F, 8'h00, 8'h7F, 8'h00, 8'h00};
   logic        clk, link_clk, pkt_accept, pkt_vc_error, vsync_out, hsync_out;
   logic        auto_recover_enable, error_indication, lane_sync_error;
   logic        rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
   logic        pkt_valid = 1'b0, pkt_is_fast_cmd = 1'b0, pkt_wc_bad = 1'b0;
   logic        pkt_is_blank = 1'b0, pkt_crc_bad = 1'b0, tx_end = 1'b0;
   logic        tx_end_pkt_seen = 1'b0, vs_in = 1'b0, hs_in = 1'b0;
   logic        pixel_valid = 1'b0, pixel_narrow = 1'b0;
   logic [1:0]  pkt_vc = 2'h0;
   logic [3:0]  lane_enabled = 4'hF, f_clk = 4'h0, f_seen = 4'h0;
   logic [3:0]  clock_lane_fault_in, lane_sync_seen;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [7:0]  c0 = 8'h7F, c1 = 8'h00, ec = 8'h7F, sts = 8'h00, snap = 8'h00;
   logic [14:0] f_lane = 15'h0, lane_fault_in;
   logic [23:0] pixel_in = 24'h0, pixel_out;
   int          n_errors = 0, samples_checked = 0;

   video_rx_error_config_regs i_video_rx_error_config_regs (
      .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .link_clk, .lane_fault_in, .clock_lane_fault_in, .lane_sync_seen,
      .lane_enabled, .pkt_valid, .pkt_vc, .pkt_is_fast_cmd, .pkt_wc_bad,
      .pkt_is_blank, .pkt_crc_bad, .tx_end, .tx_end_pkt_seen, .vs_in, .hs_in,
      .pixel_valid, .pixel_narrow, .pixel_in, .pkt_accept, .pkt_vc_error,
      .auto_recover_enable, .vsync_out, .hsync_out, .pixel_out,
      .error_indication, .lane_sync_error);
   host_lane_model i_host_lane_model (.go, .f_lane, .f_clk, .f_seen,
      .link_clk, .lane_fault_in, .clock_lane_fault_in, .lane_sync_seen);

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic finish_test;
      $display("checked %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // the whole run needs about 700 cycles
   initial begin
      #200000;
      n_errors++;
      $display("watchdog expired");
      finish_test();
   end

   task automatic chk_bit(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic chk_val(input string n, input logic [23:0] e,
                          input logic [23:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk_val($sformatf("reg %h", a), {16'h0, e}, {16'h0, reg_rdata});
   endtask

   // values settle one core cycle before the model's burst starts
   task automatic link(input logic [14:0] a, input logic [3:0] b,
                       input logic [3:0] s, input logic [3:0] e);
      @(posedge clk);
      {f_lane, f_clk, f_seen, lane_enabled} <= {a, b, s, e};
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (16) @(posedge clk);
   endtask

   function automatic logic [7:0] widen(input logic [5:0] x, input logic six);
      if (six) return {x, c1[CS_NO_GRAY] ? 2'h0 : x[5:4]};
      return {x[4:0], c1[CS_NO_GRAY] ? 3'h0 : x[4:2]};
   endfunction

   // one packet header, end marker, sync levels and narrow pixel together
   task automatic stim(input logic [7:0] r, input logic [25:0] p);
      logic        vce, acc, ee, ev;
      logic [1:0]  sy;
      logic [23:0] px;
      vce = !c0[r[1:0]];
      acc = !(r[2] & c0[CP_DROP_CMD]) & !(r[3] & !c1[CS_NO_FILTER]);
      ee = r[6] & !r[7] & !c1[CS_NO_ENDPKT];
      ev = (vce & ec[EC_BAD_VC_EN]) | (r[5] & !(r[4] & c1[CS_BLANK_CHK])) | ee;
      sy = {(c0[CP_SYNC_REGEN] & p[25]) ^ c1[CS_HS_INV],
            (c0[CP_SYNC_REGEN] & p[24]) ^ c1[CS_VS_INV]};
      px = {widen({1'b0, p[15:11]}, 1'b0), widen(p[10:5], 1'b1),
            widen({1'b0, p[4:0]}, 1'b0)};
      sts = sts | {5'h0, ee, 1'b0, ev};
      @(posedge clk);
      {tx_end_pkt_seen, tx_end, pkt_crc_bad, pkt_is_blank, pkt_wc_bad,
         pkt_is_fast_cmd, pkt_vc} <= r;
      {hs_in, vs_in, pixel_in} <= p;
      {pkt_valid, pixel_valid, pixel_narrow} <= 3'h7;
      @(posedge clk);
      {pkt_valid, tx_end, pixel_valid} <= 3'h0;
      #1;
      chk_bit("pkt_accept", acc, pkt_accept);
      chk_bit("pkt_vc_error", vce, pkt_vc_error);
      chk_val("sync_out", {22'h0, sy}, {22'h0, hsync_out, vsync_out});
      chk_val("pixel_out", px, pixel_out);
      chk_bit("auto_recover", c0[CP_RECOVER], auto_recover_enable);
      if (!c1[CS_HOLD_ERR]) chk_bit("err_pulse", ev, error_indication);
      @(posedge clk);
      #1 chk_bit("err_level", c1[CS_HOLD_ERR] & sts[0], error_indication);
   endtask

   initial begin
      logic [14:0] fl;
      logic [3:0]  fc, e, s;
      logic        err;
      void'($urandom(6));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1 chk_bit("auto_recover", 1'b1, auto_recover_enable);
      wr(OFF_LANE1_ERR, 8'hFF);
      wr(OFF_SYNC_SNAP, 8'hFF);
      wr(8'h30, 8'hFF);
      for (int i = 0; i < 10; i++) begin
         rd(OFFS[i], RSTV[i]);
      end
      $display("reset and access test done");
      for (int i = 0; i < 4; i++) begin
         fl = 15'($urandom);
         fc = 4'($urandom);
         link(fl, fc, 4'h0, 4'hF);
         rd(OFF_LANE1_ERR, {3'h0, fl[4:0]});
         rd(OFF_LANE2_ERR, {3'h0, fl[9:5]});
         rd(OFF_LANE3_ERR, {3'h0, fl[14:10]});
         rd(OFF_CLK_ERR, {4'h0, fc});
         rd(OFF_LANE1_ERR, 8'h00);
      end
      $display("lane fault test done");
      for (int i = 0; i < 6; i++) begin
         e = (i == 0) ? 4'hF : 4'($urandom);
         s = (i == 0) ? 4'h5 : 4'($urandom);
         err = ((s & e) != 4'h0) && ((s & e) != e);
         if (err) snap = {4'h0, s};
         link(15'h0, 4'h0, s, e);
         #1 chk_bit("lane_sync_error", err, lane_sync_error);
         rd(OFF_SYNC_SNAP, snap);
         @(posedge clk);
         #1 chk_bit("lane_sync_clear", 1'b0, lane_sync_error);
      end
      $display("lane sync test done");
      // disabled channel with its report enable off: channel error flag, no error pulse, no summary
      wr(OFF_CFG_PRI, 8'h0E);
      wr(OFF_ERR_CFG, 8'h77);
      c0 = 8'h0E;
      ec = 8'h77;
      stim(8'h04, 26'h0);
      rd(OFF_PROT_STS, sts);
      sts = 8'h00;
      for (int i = 0; i < 24; i++) begin
         c0 = 8'($urandom) & CP_WR_MASK;
         c1 = 8'($urandom);
         ec = 8'($urandom) & EC_WR_MASK;
         wr(OFF_CFG_PRI, c0 | 8'h80);
         wr(OFF_CFG_SEC, c1);
         wr(OFF_ERR_CFG, ec | 8'h80);
         stim(8'($urandom), 26'($urandom));
         rd(OFF_PROT_STS, sts);
         sts = 8'h00;
         rd(OFF_CFG_PRI, c0);
         rd(OFF_CFG_SEC, c1);
         rd(OFF_ERR_CFG, ec);
      end
      $display("packet and configuration test done");
      finish_test();
   end
endmodule // video_rx_error_config_regs_test
`default_nettype wire
